// [pkg/ppl_map.svh]
// Purpose: constants for the passive parallel configuration loader
// Assumes: pclk at 100 MHz
// Notes: register offsets are byte addresses on the APB bus
`ifndef PPL_MAP_SVH
`define PPL_MAP_SVH

`define PPL_CLK_MHZ 100
`define PPL_CLK_NS 10
`define PPL_T_STATUS_MIN_US 268
`define PPL_T_INIT_MIN_US 175
`define PPL_T_CD2CU_NS 40
`define PPL_USER_EDGES 8576
`define PPL_POR_CYCLES 2000
`define PPL_TMR_W 20
`define PPL_INIT_FALLS 2'h2

`define PPL_ADDR_W 8
`define PPL_OFF_CTRL 8'h00
`define PPL_OFF_LENGTH 8'h04
`define PPL_OFF_STATUS 8'h08
`define PPL_OFF_WORDCNT 8'h0C
`define PPL_OFF_LASTWORD 8'h10
`define PPL_OFF_KEY 8'h14

`define PPL_CTRL_W 7
`define PPL_CTRL_RST 7'h00
`define PPL_LEN_RST 32'h0000_0100
`define PPL_KEY_RST 32'h0000_0000
`define PPL_MASK8 32'h0000_00FF
`define PPL_MASK16 32'h0000_FFFF

`endif

// [pkg/ppl_pkg.sv]
// Purpose: types shared by the configuration loader
// Assumes: ppl_map.svh supplies the numeric constants
// Notes: ctrl struct layout is the CTRL register layout, lsb last
package ppl_pkg;

	typedef enum logic [1:0] {
		PPL_W8 = 2'h0,
		PPL_W16 = 2'h1,
		PPL_W32 = 2'h2
	} ppl_width_e;

	typedef enum logic [2:0] {
		PPL_POR = 3'h0,
		PPL_HOLD = 3'h1,
		PPL_LOAD = 3'h3,
		PPL_TAIL = 3'h2,
		PPL_INIT = 3'h6,
		PPL_USER = 3'h7
	} ppl_state_e;

	typedef struct packed {
		logic dual_pin_en;
		logic user_clk_sel;
		logic init_done_en;
		logic decrypt_en;
		logic decompress_en;
		logic [1:0] width;
	} ppl_ctrl_s;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} ppl_word_s;

endpackage

// [rtl/ppl_sync.sv]
// Purpose: two-flop synchroniser for pins entering the pclk domain
// Assumes: each bit is a level; no bit relation is preserved across bits
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module ppl_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	generate
		if (W < 1)
		begin : g_chk
			$error("ppl_sync width must be at least one");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta_reg;
			logic sync_reg;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end
				else
				begin
					meta_reg <= d[i];
					sync_reg <= meta_reg;
				end
			end
			assign q[i] = sync_reg;
		end
	endgenerate
endmodule // ppl_sync
`default_nettype wire

// [rtl/ppl_top.sv]
// Purpose: device side of a passive parallel configuration load
// Assumes: config_clock and all pins are asynchronous to pclk and slower than pclk/4
// Notes: the word transform is a stand-in for the real decrypt/decompress datapath
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ppl_map.svh"
module ppl_top #(
	parameter int POR_CYCLES = `PPL_POR_CYCLES,
	parameter int STATUS_CYCLES = `PPL_T_STATUS_MIN_US * `PPL_CLK_MHZ,
	parameter int INIT_CYCLES = `PPL_T_INIT_MIN_US * `PPL_CLK_MHZ,
	parameter int USER_EDGES = `PPL_USER_EDGES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PPL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic config_clock,
	input wire logic start_req_n,
	input wire logic status_n_i,
	output logic status_n_o,
	output logic status_n_oe,
	input wire logic load_done_i,
	output logic load_done_o,
	output logic load_done_oe,
	output logic init_done_o,
	output logic init_done_oe,
	input wire logic [31:0] data_i,
	input wire logic user_init_clock,
	output logic user_mode,
	output logic [31:0] user_pins,
	output ppl_pkg::ppl_word_s word_out
);
	import ppl_pkg::*;

	localparam int TW = `PPL_TMR_W;
	localparam int CU_CYCLES = (`PPL_T_CD2CU_NS + `PPL_CLK_NS - 1) / `PPL_CLK_NS;

	generate
		if (POR_CYCLES < 1 || STATUS_CYCLES < 1 || INIT_CYCLES < 1 || USER_EDGES < 1 ||
			POR_CYCLES >= 2**TW || STATUS_CYCLES >= 2**TW || INIT_CYCLES >= 2**TW || USER_EDGES >= 2**TW)
		begin : g_chk
			$error("ppl_top counts must lie between 1 and the timer range");
		end
	endgenerate

	logic [36:0] sync_q;
	logic s_cclk, s_start_n, s_status, s_done, s_uclk;
	logic [31:0] s_data;

	ppl_sync #(.W(37)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({data_i, user_init_clock, load_done_i, status_n_i, start_req_n, config_clock}),
		.q(sync_q)
	);
	assign s_cclk = sync_q[0];
	assign s_start_n = sync_q[1];
	assign s_status = sync_q[2];
	assign s_done = sync_q[3];
	assign s_uclk = sync_q[4];
	assign s_data = sync_q[36:5];

	// registers seen by software
	logic [`PPL_CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [31:0] len_reg, len_next, key_reg, key_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	ppl_ctrl_s ctrl;
	assign ctrl = ppl_ctrl_s'(ctrl_reg);

	// load sequencer state
	ppl_state_e state_reg, state_next;
	logic [TW-1:0] tmr_reg, tmr_next;
	logic [3:0] cyc_reg, cyc_next;
	logic [1:0] fall_reg, fall_next;
	logic uc_phase_reg, uc_phase_next;
	logic cclk_d_reg, cclk_d_next, uclk_d_reg, uclk_d_next;
	logic [31:0] wcnt_reg, wcnt_next, wbuf_reg, wbuf_next, last_reg, last_next;
	logic [31:0] pins_reg, pins_next;
	ppl_word_s wout_reg, wout_next;
	logic st_oe_reg, st_oe_next, cd_oe_reg, cd_oe_next, id_oe_reg, id_oe_next, um_reg, um_next;

	logic cclk_rise, cclk_fall, uclk_rise;
	logic [3:0] ratio;
	logic [31:0] masked;

	assign cclk_rise = s_cclk & ~cclk_d_reg;
	assign cclk_fall = ~s_cclk & cclk_d_reg;
	assign uclk_rise = s_uclk & ~uclk_d_reg;

	function automatic logic [3:0] ppl_ratio(input ppl_ctrl_s c);
		logic [3:0] r;
		r = 4'h1;
		case (ppl_width_e'(c.width))
			PPL_W8: r = c.decompress_en ? 4'h2 : 4'h1;
			PPL_W16: r = c.decompress_en ? 4'h4 : (c.decrypt_en ? 4'h2 : 4'h1);
			default: r = c.decompress_en ? 4'h8 : (c.decrypt_en ? 4'h4 : 4'h1);
		endcase
		return r;
	endfunction

	always_comb
	begin
		ratio = ppl_ratio(ctrl);
		case (ppl_width_e'(ctrl.width))
			PPL_W8: masked = s_data & `PPL_MASK8;
			PPL_W16: masked = s_data & `PPL_MASK16;
			default: masked = s_data;
		endcase
	end

	// apb slave: zero wait states, pready high in every access phase
	always_comb
	begin
		ctrl_next = ctrl_reg;
		len_next = len_reg;
		key_next = key_reg;
		prdata_next = prdata_reg;
		pready_next = psel & ~penable;
		pslverr_next = 1'b0;
		if (psel && !penable)
		begin
			case (paddr)
				`PPL_OFF_CTRL: prdata_next = {{(32-`PPL_CTRL_W){1'b0}}, ctrl_reg};
				`PPL_OFF_LENGTH: prdata_next = len_reg;
				`PPL_OFF_STATUS: prdata_next = {25'h0, s_done, um_reg, ~id_oe_reg, s_status, state_reg};
				`PPL_OFF_WORDCNT: prdata_next = wcnt_reg;
				`PPL_OFF_LASTWORD: prdata_next = last_reg;
				`PPL_OFF_KEY: prdata_next = 32'h0000_0000;
				default:
				begin
					prdata_next = 32'h0000_0000;
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (psel && penable && pready_reg && pwrite)
		begin
			case (paddr)
				`PPL_OFF_CTRL: ctrl_next = pwdata[`PPL_CTRL_W-1:0];
				`PPL_OFF_LENGTH: len_next = pwdata;
				`PPL_OFF_KEY: key_next = pwdata;
				default: ctrl_next = ctrl_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= `PPL_CTRL_RST;
			len_reg <= `PPL_LEN_RST;
			key_reg <= `PPL_KEY_RST;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			len_reg <= len_next;
			key_reg <= key_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		cyc_next = cyc_reg;
		fall_next = fall_reg;
		uc_phase_next = uc_phase_reg;
		cclk_d_next = s_cclk;
		uclk_d_next = s_uclk;
		wcnt_next = wcnt_reg;
		wbuf_next = wbuf_reg;
		last_next = last_reg;
		pins_next = pins_reg;
		wout_next = '{valid: 1'b0, data: wout_reg.data};
		case (state_reg)
			PPL_POR:
			begin
				if (tmr_reg >= TW'(POR_CYCLES - 1))
				begin
					state_next = PPL_HOLD;
					tmr_next = TW'(STATUS_CYCLES);
				end
				else
					tmr_next = tmr_reg + 1'b1;
			end
			PPL_HOLD:
			begin
				// timer restarts while the request is low, so the minimum counts from its rise
				if (tmr_reg < TW'(STATUS_CYCLES))
					tmr_next = tmr_reg + 1'b1;
				if (s_start_n && tmr_reg >= TW'(STATUS_CYCLES - 1))
				begin
					state_next = PPL_LOAD;
					cyc_next = 4'h0;
					wcnt_next = 32'h0000_0000;
				end
			end
			PPL_LOAD:
			begin
				// an externally held status line stalls the load
				if (cclk_rise && s_status)
				begin
					if (cyc_reg == 4'h0)
						wbuf_next = masked;
					if (cyc_reg == ratio - 4'h1)
					begin
						cyc_next = 4'h0;
						wcnt_next = wcnt_reg + 1'b1;
						last_next = (cyc_reg == 4'h0 ? masked : wbuf_reg) ^ (ctrl.decrypt_en ? key_reg : 32'h0000_0000);
						wout_next = '{valid: 1'b1, data: last_next};
						if (wcnt_reg + 1'b1 == len_reg)
						begin
							state_next = PPL_TAIL;
							fall_next = 2'h0;
						end
					end
					else
						cyc_next = cyc_reg + 1'b1;
				end
			end
			PPL_TAIL:
			begin
				if (cclk_fall)
					fall_next = fall_reg + 1'b1;
				if (cclk_fall && fall_reg == `PPL_INIT_FALLS - 2'h1)
				begin
					state_next = PPL_INIT;
					tmr_next = '0;
					uc_phase_next = 1'b0;
				end
			end
			PPL_INIT:
			begin
				if (ctrl.user_clk_sel)
				begin
					if (!uc_phase_reg)
					begin
						tmr_next = tmr_reg + 1'b1;
						if (tmr_reg >= TW'(CU_CYCLES - 1))
						begin
							uc_phase_next = 1'b1;
							tmr_next = '0;
						end
					end
					else if (uclk_rise)
					begin
						tmr_next = tmr_reg + 1'b1;
						if (tmr_reg >= TW'(USER_EDGES - 1))
							state_next = PPL_USER;
					end
				end
				else
				begin
					tmr_next = tmr_reg + 1'b1;
					if (tmr_reg >= TW'(INIT_CYCLES - 1))
						state_next = PPL_USER;
				end
			end
			PPL_USER:
			begin
				// config clock edges have no effect here
			end
			default:
				state_next = PPL_POR;
		endcase
		// restart has priority over every step above except the power-on wait
		if (!s_start_n && state_reg != PPL_POR)
		begin
			state_next = PPL_HOLD;
			tmr_next = '0;
		end
		st_oe_next = (state_next == PPL_POR) || (state_next == PPL_HOLD);
		cd_oe_next = (state_next == PPL_POR) || (state_next == PPL_HOLD) || (state_next == PPL_LOAD);
		id_oe_next = ctrl.init_done_en && (state_next == PPL_TAIL || state_next == PPL_INIT);
		um_next = (state_next == PPL_USER);
		pins_next = (state_next == PPL_USER && ctrl.dual_pin_en) ? s_data : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= PPL_POR;
			tmr_reg <= '0;
			cyc_reg <= 4'h0;
			fall_reg <= 2'h0;
			uc_phase_reg <= 1'b0;
			cclk_d_reg <= 1'b0;
			uclk_d_reg <= 1'b0;
			wcnt_reg <= 32'h0000_0000;
			wbuf_reg <= 32'h0000_0000;
			last_reg <= 32'h0000_0000;
			pins_reg <= 32'h0000_0000;
			wout_reg <= '0;
			st_oe_reg <= 1'b1;
			cd_oe_reg <= 1'b1;
			id_oe_reg <= 1'b0;
			um_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			cyc_reg <= cyc_next;
			fall_reg <= fall_next;
			uc_phase_reg <= uc_phase_next;
			cclk_d_reg <= cclk_d_next;
			uclk_d_reg <= uclk_d_next;
			wcnt_reg <= wcnt_next;
			wbuf_reg <= wbuf_next;
			last_reg <= last_next;
			pins_reg <= pins_next;
			wout_reg <= wout_next;
			st_oe_reg <= st_oe_next;
			cd_oe_reg <= cd_oe_next;
			id_oe_reg <= id_oe_next;
			um_reg <= um_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	// open-drain pins only ever pull low
	assign status_n_o = 1'b0;
	assign load_done_o = 1'b0;
	assign init_done_o = 1'b0;
	assign status_n_oe = st_oe_reg;
	assign load_done_oe = cd_oe_reg;
	assign init_done_oe = id_oe_reg;
	assign user_mode = um_reg;
	assign user_pins = pins_reg;
	assign word_out = wout_reg;
endmodule // ppl_top
`default_nettype wire

// [dv/ppl_chk.sv]
// Purpose: port checks for the configuration loader
// Assumes: bound into ppl_top, one pclk domain
// Notes: counters replace windows too long to unroll
`timescale 1ns/100ps
`default_nettype none
module ppl_chk #(
	parameter int POR_CYCLES = 20,
	parameter int INIT_CYCLES = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic start_req_n,
	input wire logic status_n_oe,
	input wire logic load_done_oe,
	input wire logic init_done_oe,
	input wire logic user_mode,
	input wire logic [31:0] user_pins,
	input wire ppl_pkg::ppl_word_s word_out
);
	import ppl_pkg::*;
	int lo_cnt;
	int cd_cnt;
	int wt_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lo_cnt <= 0;
			cd_cnt <= 0;
			wt_cnt <= 0;
		end
		else
		begin
			lo_cnt <= status_n_oe ? lo_cnt + 1 : 0;
			cd_cnt <= load_done_oe ? 0 : cd_cnt + 1;
			wt_cnt <= (status_n_oe && start_req_n) ? wt_cnt + 1 : 0;
		end
	end
	user_lines_a: assert property (user_mode |-> !status_n_oe && !load_done_oe && !init_done_oe)
		else $error("user mode line held low");
	start_pull_a: assert property ($fell(start_req_n) |-> ##[1:60] (status_n_oe && load_done_oe))
		else $error("start fall not answered");
	status_min_a: assert property ($fell(status_n_oe) |-> lo_cnt >= POR_CYCLES)
		else $error("status pulse short");
	status_rel_a: assert property ($fell(status_n_oe) |-> $past(start_req_n) && wt_cnt < 150600)
		else $error("status release wrong");
	done_rel_a: assert property ($fell(load_done_oe) |-> word_out.valid || $past(word_out.valid))
		else $error("flag released without word");
	init_min_a: assert property ($rose(user_mode) |-> cd_cnt >= INIT_CYCLES)
		else $error("user mode too early");
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access");
	bad_addr_a: assert property (psel && !penable && !pwrite && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	word_pulse_a: assert property (word_out.valid |=> !word_out.valid)
		else $error("word pulse too long");
	pins_idle_a: assert property (!user_mode |-> user_pins == 32'h0)
		else $error("user pins before user mode");
endmodule // ppl_chk
bind ppl_top ppl_chk #(.POR_CYCLES(POR_CYCLES), .INIT_CYCLES(INIT_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .start_req_n(start_req_n),
	.status_n_oe(status_n_oe), .load_done_oe(load_done_oe), .init_done_oe(init_done_oe),
	.user_mode(user_mode), .user_pins(user_pins), .word_out(word_out));
`default_nettype wire

// [dv/ppl_host.sv]
// Purpose: external configuration host driving clock, data and start
// Assumes: config clock 160 ns, stopped low between words
// Notes: released data lines show the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module ppl_host (
	input wire logic pclk,
	input wire logic status_n,
	output logic config_clock,
	output logic start_req_n,
	output logic [31:0] data
);
	logic [31:0] last;
	initial
	begin
		config_clock = 1'h0;
		start_req_n = 1'h1;
		data = 32'h0;
		last = 32'h0;
	end
	task automatic put(input logic [31:0] d);
		@(posedge pclk);
		data <= d;
		last = d;
	endtask
	task automatic pulse();
		repeat (8) @(posedge pclk);
		config_clock <= 1'h1;
		repeat (8) @(posedge pclk);
		config_clock <= 1'h0;
	endtask
	task automatic restart();
		@(posedge pclk);
		start_req_n <= 1'h0;
		repeat (200) @(posedge pclk);
		start_req_n <= 1'h1;
		data <= ~last;
		while (status_n !== 1'h1)
			@(posedge pclk);
		repeat (200) @(posedge pclk);
	endtask
endmodule // ppl_host
`default_nettype wire

// [dv/parallel_passive_config_load_test.sv]
// Purpose: self-checking bench for the configuration loader
// Assumes: shortened timers, pulled-up open-drain lines
// Notes: every width and option pair is loaded once
`timescale 1ns/100ps
`default_nettype none
module parallel_passive_config_load_test;
	import ppl_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] ucnt = 3'h0;
	logic [31:0] seed = 32'h0000_F15F;
	logic [31:0] prdata, user_pins, data_i;
	logic pready, pslverr, status_n_oe, load_done_oe, init_done_oe, user_mode, config_clock, start_req_n;
	ppl_word_s word_out;
	wire status_n_i = ~status_n_oe;
	wire load_done_i = ~load_done_oe;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int nwo = 0;
	logic [31:0] expq [$];
	always #5 pclk = ~pclk;
	always @(posedge pclk) ucnt <= ucnt + 3'h1;
	ppl_top #(.POR_CYCLES(20), .STATUS_CYCLES(50), .INIT_CYCLES(40), .USER_EDGES(8)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .config_clock(config_clock),
		.start_req_n(start_req_n), .status_n_i(status_n_i), .status_n_o(), .status_n_oe(status_n_oe),
		.load_done_i(load_done_i), .load_done_o(), .load_done_oe(load_done_oe), .init_done_o(),
		.init_done_oe(init_done_oe), .data_i(data_i), .user_init_clock(ucnt[2]), .user_mode(user_mode),
		.user_pins(user_pins), .word_out(word_out));
	ppl_host host (.pclk(pclk), .status_n(status_n_i), .config_clock(config_clock),
		.start_req_n(start_req_n), .data(data_i));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tally_and_finish();
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		chk(q & m, exp);
	endtask
	// a stray word with nothing expected always mismatches
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_fail++;
			tally_and_finish();
		end
		if (word_out.valid === 1'h1)
		begin
			nwo++;
			chk(word_out.data, expq.size() ? expq.pop_front() : ~word_out.data);
		end
	end
	initial
	begin
		int c, k, r, nw, tot;
		logic [31:0] d, key, opt, m, q, lw;
		logic e;
		tot = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk({30'h0, status_n_oe, load_done_oe}, 32'h3);
		rd(8'h00, 32'h0, 32'hFFFF_FFFF);
		rd(8'h04, 32'h100, 32'hFFFF_FFFF);
		wr(8'h14, 32'h1234_5678);
		rd(8'h14, 32'h0, 32'hFFFF_FFFF);
		apb(1'h0, 8'h20, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		for (c = 0; c < 12; c++)
		begin
			opt = rnd();
			key = rnd();
			nw = 1 + opt[4:3];
			r = c[1] ? 2 << c[3:2] : (c[0] ? 1 << c[3:2] : 1);
			m = c[3:2] == 0 ? 32'hFF : (c[3:2] == 1 ? 32'hFFFF : 32'hFFFF_FFFF);
			wr(8'h00, {25'h0, opt[2:0], c[0], c[1], c[3:2]});
			wr(8'h04, 32'(nw));
			wr(8'h14, key);
			host.restart();
			chk({31'h0, load_done_oe}, 32'h1);
			for (k = 0; k < nw; k++)
			begin
				d = rnd();
				lw = (d & m) ^ (c[0] ? key : 32'h0);
				expq.push_back(lw);
				host.put(d);
				repeat (r - 1) host.pulse();
				chk(32'(nwo), 32'(tot));
				chk({31'h0, load_done_oe}, 32'h1);
				host.pulse();
				tot++;
			end
			repeat (6) @(posedge pclk);
			chk({30'h0, load_done_oe, init_done_oe}, {30'h0, 1'h0, opt[0]});
			rd(8'h08, 32'h2, 32'h7);
			host.pulse();
			repeat (6) @(posedge pclk);
			rd(8'h08, 32'h6, 32'h7);
			for (k = 0; k < 3000 && user_mode !== 1'h1; k++)
				@(posedge pclk);
			chk({30'h0, user_mode, init_done_oe}, 32'h2);
			d = rnd();
			host.put(d);
			repeat (6) @(posedge pclk);
			chk(user_pins, opt[2] ? d : 32'h0);
			host.pulse();
			repeat (4) @(posedge pclk);
			chk({31'h0, user_mode}, 32'h1);
			rd(8'h0C, 32'(nw), 32'hFFFF_FFFF);
			rd(8'h10, lw, 32'hFFFF_FFFF);
		end
		tally_and_finish();
	end
endmodule // parallel_passive_config_load_test
`default_nettype wire
